// File: verilog/asc_defs.vh
// Purpose: shared constants of the serial control word decoder
// Assumes: included by bare name from the design files
// Notes: offsets are Avalon-MM byte addresses
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH

// register map
`define ASC_REG_STATUS 4'h0
`define ASC_REG_CONFIG 4'h4
`define ASC_REG_RESULT 4'h8
`define ASC_CONFIG_RST 1'b1

// control word layout, bit positions
`define ASC_SEL_HI 7
`define ASC_SEL_LO 4
`define ASC_LEN_HI 3
`define ASC_LEN_LO 2
`define ASC_ORDER_BIT 1
`define ASC_FMT_BIT 0
`define ASC_CTRL_RST 8'hE0

// input-select codes
`define ASC_NUM_CHAN 4'hB
`define ASC_SEL_PD 4'hE

// length codes and lengths in shift-clock periods
`define ASC_LEN_CODE_8 2'h1
`define ASC_LEN_CODE_16 2'h3
`define ASC_LEN_8 5'h08
`define ASC_LEN_12 5'h0C
`define ASC_LEN_16 5'h10

// edge counts at which things happen
`define ASC_LEN_RISE 5'h06
`define ASC_PD_FALL 5'h04
`define ASC_CTRL_BITS 5'h08

`endif

// File: verilog/asc_sync.v
// Purpose: two-flop synchroniser for inputs from outside the clock domain
// Assumes: inputs are levels, each bit independent
// Notes: only the second stage may be read by any logic
`timescale 1ns/100ps
module asc_sync #(
    parameter W = 3
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_r;
            reg sync_r;
            // first stage feeds the second stage only
            always @(posedge clk_i) begin
                if (sys_rst_i) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= d_i[g];
                    sync_r <= meta_r;
                end
            end
            assign q_o[g] = sync_r;
        end
    endgenerate
endmodule // asc_sync

// File: verilog/asc_fifo2.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock
// Notes: full and empty are exact; in_ready_o drops when both slots hold
`timescale 1ns/100ps
module asc_fifo2 #(
    parameter W = 12
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem_r [0:1];
    reg wr_ptr_r;
    reg rd_ptr_r;
    reg [1:0] count_r;
    wire push;
    wire pop;

    // handshakes are combinational from the fill count
    assign in_ready_o = (count_r != 2'h2);
    assign out_valid_o = (count_r != 2'h0);
    assign out_data_o = mem_r[rd_ptr_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // storage and pointers
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= in_data_i;
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push & ~pop) begin
                count_r <= count_r + 2'h1;
            end else if (pop & ~push) begin
                count_r <= count_r - 2'h1;
            end
        end
    end
endmodule // asc_fifo2

// File: verilog/asc_top.v
// Purpose: device-side decoder of the serial control word of a 12-bit ADC
// Assumes: shift clock is a slow pin, sampled here at 25 MHz
// Notes: conversion results arrive on a stream port through a 2-entry buffer
//        CONFIG enable gates every shift-clock edge of the link
// Function
// - top four word bits select eleven inputs, reference test or power-down
// - select address applies to the conversion right after its I/O cycle
// - length bits apply to the same I/O cycle that carries them
// - length code 00 or 10 gives 12-bit output in the same cycle
// - in 12-bit mode conversion starts after the twelfth falling edge
// - code 11 gives sixteen output bits, lowest four always zero
// - 16-bit cycle is sixteen clocks; conversion starts after sixteenth fall
// - length code 01 gives 8-bit output in the same cycle
// - 8-bit mode drops the four lowest result bits
// - 8-bit cycle is eight clocks; conversion starts after eighth fall
// - length change takes effect after six rising shift-clock edges
// - a length change may corrupt one LSB-first result at most
// - format bit 0 unsigned, 1 two's complement; MSBs are complements
// - order bit 0 MSB first, 1 LSB first, from next I/O cycle
// - select 1110 powers down at fourth falling edge; cycle still ends
// - each later falling edge advances output until length is sent
`timescale 1ns/100ps
`include "asc_defs.vh"
module asc_top #(
    parameter RES_W = 12
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    input wire io_clk_i,
    input wire cs_n_i,
    input wire sdi_i,
    output reg sdo_o,
    output wire sdo_oe_n_o,
    output wire eoc_o,
    output reg conv_start_o,
    output reg [3:0] conv_sel_o,
    input wire res_valid_i,
    output wire res_ready_o,
    input wire [RES_W-1:0] res_data_i
);
    // synchronised pins
    wire [2:0] pin_s;
    wire sclk_s;
    wire cs_n_s;
    wire sdi_s;
    reg sclk_d_r;
    reg cs_n_d_r;
    wire rise;
    wire fall;
    wire cs_fall;
    wire link_on;

    // control word and cycle state
    reg [7:0] ctrl_sr_r;
    reg [7:0] ctrl_last_r;
    reg [4:0] rise_cnt_r;
    reg [4:0] fall_cnt_r;
    reg [4:0] len_cur_r;
    reg order_r;
    reg fmt_r;
    reg pd_r;
    reg busy_r;
    reg [15:0] out_word_r;
    reg [RES_W-1:0] last_res_r;
    reg cfg_en_r;
    reg ack_r;

    wire [4:0] fall_nxt;
    wire [3:0] sel_now;
    wire end_cycle;
    wire [RES_W-1:0] buf_data;
    wire buf_valid;
    wire load;
    wire take_ok;
    wire [RES_W-1:0] coded;
    wire avs_req;

    // select enters the synchroniser inverted: the stages reset to zero,
    // which then reads as deselected, so no false select edge follows reset
    asc_sync #(
        .W(3)
    ) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i({io_clk_i, ~cs_n_i, sdi_i}),
        .q_o(pin_s)
    );

    // results wait here so a late conversion slot loses no word
    asc_fifo2 #(
        .W(RES_W)
    ) u_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(res_valid_i),
        .in_ready_o(res_ready_o),
        .in_data_i(res_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(take_ok),
        .out_data_o(buf_data)
    );

    assign sclk_s = pin_s[2];
    assign cs_n_s = ~pin_s[1];
    assign sdi_s = pin_s[0];

    // edge detection on the resampled shift clock and select
    // edges count only while selected and enabled
    assign link_on = ~cs_n_s & cfg_en_r;
    assign rise = link_on & sclk_s & ~sclk_d_r;
    assign fall = link_on & ~sclk_s & sclk_d_r;
    assign cs_fall = ~cs_n_s & cs_n_d_r;
    assign fall_nxt = fall_cnt_r + 5'h01;
    assign sel_now = ctrl_sr_r[3:0];
    assign end_cycle = fall & (fall_nxt == len_cur_r);
    // no result is taken on the edge that ends a cycle: that edge starts a
    // conversion, and a word popped then would be dropped unseen
    assign take_ok = busy_r & ~end_cycle;
    assign load = take_ok & buf_valid;

    // two's complement differs from unsigned only in the inverted MSB
    assign coded = fmt_r ? {~buf_data[RES_W-1], buf_data[RES_W-2:0]}
                         : buf_data;

    // length in periods from the two length bits
    // codes 00 and 10 both give twelve; only 01 and 11 shorten or pad
    function [4:0] f_len;
        input [1:0] code;
        begin
            if (code == `ASC_LEN_CODE_8) begin
                f_len = `ASC_LEN_8;
            end else if (code == `ASC_LEN_CODE_16) begin
                f_len = `ASC_LEN_16;
            end else begin
                f_len = `ASC_LEN_12;
            end
        end
    endfunction

    // bit k of the MSB-justified 16-bit image for the given order and length
    // out-of-range indices read zero, so an extra fall only shows a zero
    function f_bit;
        input [15:0] word;
        input [4:0] k;
        input lsb;
        input [4:0] len;
        reg [4:0] idx;
        begin
            idx = 5'h00;
            if (lsb) begin
                idx = (`ASC_LEN_16 - len) + k; // pad bits lead in 16-bit
            end else begin
                idx = 5'h0F - k;
            end
            if (idx > 5'h0F) begin
                f_bit = 1'b0;
            end else begin
                f_bit = word[idx[3:0]];
            end
        end
    endfunction

    // pin delay stages for edge detection
    // reset values match the idle pins: clock low, select high
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    // control word capture and I/O cycle sequencing
    // a cycle is counted in falling edges; the length in force decides which
    // fall ends it, and select high or a disabled link discards the count
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_sr_r <= `ASC_CTRL_RST;
            ctrl_last_r <= `ASC_CTRL_RST;
            rise_cnt_r <= 5'h00;
            fall_cnt_r <= 5'h00;
            len_cur_r <= `ASC_LEN_12;
            order_r <= 1'b0;
            fmt_r <= 1'b0;
            pd_r <= 1'b1; // starts powered down until a valid address
            busy_r <= 1'b0;
            out_word_r <= 16'h0000;
            last_res_r <= {RES_W{1'b0}};
            sdo_o <= 1'b0;
            conv_start_o <= 1'b0;
            conv_sel_o <= 4'h0;
        end else begin
            // start is a one-cycle pulse
            conv_start_o <= 1'b0;
            if (~link_on) begin
                // select high or link disabled: clock inhibited, cycle reset
                rise_cnt_r <= 5'h00;
                fall_cnt_r <= 5'h00;
            end
            // the first eight rises shift the word in, later rises are ignored
            if (rise) begin
                if (rise_cnt_r < `ASC_CTRL_BITS) begin
                    ctrl_sr_r <= {ctrl_sr_r[6:0], sdi_s};
                    rise_cnt_r <= rise_cnt_r + 5'h01;
                end
                // sixth rise holds both length bits; earlier bits still
                // shift with the old length, which may garble LSB-first data
                if (rise_cnt_r + 5'h01 == `ASC_LEN_RISE) begin
                    len_cur_r <= f_len({ctrl_sr_r[0], sdi_s});
                end
            end
            if (fall) begin
                fall_cnt_r <= fall_nxt;
                // power-down takes hold at the fourth fall; the cycle goes on
                if ((fall_nxt == `ASC_PD_FALL) && (sel_now == `ASC_SEL_PD)) begin
                    pd_r <= 1'b1;
                end
                // advance one result bit per falling edge
                sdo_o <= busy_r ? 1'b0
                         : f_bit(out_word_r, fall_nxt, order_r,
                                 len_cur_r);
            end
            if (end_cycle) begin
                // last falling edge of 8, 12 or 16 ends the cycle
                rise_cnt_r <= 5'h00;
                fall_cnt_r <= 5'h00;
                ctrl_last_r <= ctrl_sr_r;
                order_r <= ctrl_sr_r[`ASC_ORDER_BIT];
                // a power-down word ends the cycle without a start
                if (ctrl_sr_r[`ASC_SEL_HI:`ASC_SEL_LO] != `ASC_SEL_PD) begin
                    pd_r <= 1'b0;
                    busy_r <= 1'b1;
                    conv_start_o <= 1'b1;
                    conv_sel_o <= ctrl_sr_r[`ASC_SEL_HI:`ASC_SEL_LO];
                    fmt_r <= ctrl_sr_r[`ASC_FMT_BIT];
                    sdo_o <= 1'b0; // output forced low while converting
                end
            end else if (load) begin
                // result latched: 4 pad zeros below the 12 result bits
                busy_r <= 1'b0;
                out_word_r <= {coded, 4'h0};
                last_res_r <= coded;
                sdo_o <= f_bit({coded, 4'h0}, 5'h00, order_r, len_cur_r);
            end else if (cs_fall & ~busy_r) begin
                // first bit appears as select goes low
                sdo_o <= f_bit(out_word_r, 5'h00, order_r, len_cur_r);
            end
        end
    end

    // serial output is released whenever select is high
    assign sdo_oe_n_o = cs_n_s;
    // eoc is high when idle and low from a start until the result is taken
    assign eoc_o = ~busy_r;

    // Avalon slave: one wait cycle, answer on the second edge
    // read data is captured on the first edge so it stands when wait drops
    assign avs_req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = avs_req & ~ack_r;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_r <= 1'b0;
            cfg_en_r <= `ASC_CONFIG_RST;
            avs_readdata_o <= 32'h00000000;
        end else begin
            // ack alternates so each access sees exactly one wait cycle
            ack_r <= avs_req & ~ack_r;
            if (avs_read_i & ~ack_r) begin
                case (avs_address_i)
                    `ASC_REG_STATUS: begin
                        avs_readdata_o <= {16'h0000, len_cur_r, order_r,
                                           ~busy_r, pd_r, ctrl_last_r};
                    end
                    `ASC_REG_CONFIG: begin
                        avs_readdata_o <= {31'h00000000, cfg_en_r};
                    end
                    `ASC_REG_RESULT: begin
                        avs_readdata_o <= {15'h0000, fmt_r, 4'h0, last_res_r};
                    end
                    default: begin
                        avs_readdata_o <= 32'h00000000; // unmapped reads zero
                    end
                endcase
            end
            // a write lands on the edge where waitrequest is low
            if (avs_write_i & ack_r & avs_byteenable_i[0]
                    & (avs_address_i == `ASC_REG_CONFIG)) begin
                cfg_en_r <= avs_writedata_i[0];
            end
        end
    end
endmodule // asc_top

// File: testbench/asc_top_chk.sv
// Purpose: port-level checker for the control word decoder
// Assumes: shift clock pin sampled in the clk_i domain
// Notes: bound to asc_top below
`timescale 1ns/100ps
module asc_top_chk (
    input wire clk_i,
    input wire sys_rst_i,
    input wire avs_read_i,
    input wire avs_waitrequest_o,
    input wire io_clk_i,
    input wire sdo_o,
    input wire eoc_o,
    input wire conv_start_o,
    input wire [3:0] conv_sel_o
);
    reg io_q_r;
    reg [3:0] since_fall_r;
    // cycles since the shift clock pin fell; saturates so it never wraps
    always @(posedge clk_i) begin
        io_q_r <= io_clk_i;
        if (sys_rst_i || (io_q_r && !io_clk_i))
            since_fall_r <= 4'h0;
        else if (since_fall_r != 4'hF)
            since_fall_r <= since_fall_r + 4'h1;
    end
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_start_eoc: assert property (conv_start_o |=> !eoc_o)
        else $error("eoc stayed high after a start");
    chk_start_single: assert property (
        conv_start_o |=> !conv_start_o) else $error("start pulse too long");
    chk_start_fall: assert property (
        conv_start_o |-> since_fall_r <= 4'h8)
        else $error("start not tied to a falling edge");
    chk_pd_nostart: assert property (
        conv_start_o |-> conv_sel_o != 4'hE)
        else $error("conversion started in power-down");
    chk_sel_held: assert property (
        !eoc_o && !conv_start_o |-> $stable(conv_sel_o))
        else $error("select moved during conversion");
    chk_sdo_zero: assert property (!eoc_o ##1 !eoc_o |-> !sdo_o)
        else $error("serial output not zero while converting");
    chk_sdo_fall: assert property (
        eoc_o && $past(eoc_o) && $past(eoc_o, 2) && !$stable(sdo_o)
        |-> since_fall_r <= 4'h6) else $error("output moved without a fall");
    chk_eoc_cause: assert property (
        $fell(eoc_o) |-> conv_start_o || $past(conv_start_o))
        else $error("eoc fell without a start");
    chk_bus_wait: assert property ( // one wait state per read access
        $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read wait state count wrong");
    cover property (conv_start_o);
    cover property ($rose(eoc_o));
    cover property (conv_start_o && conv_sel_o == 4'hB);
endmodule // asc_top_chk

bind asc_top asc_top_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .avs_read_i(avs_read_i), .avs_waitrequest_o(avs_waitrequest_o),
    .io_clk_i(io_clk_i), .sdo_o(sdo_o), .eoc_o(eoc_o),
    .conv_start_o(conv_start_o), .conv_sel_o(conv_sel_o));

// File: testbench/asc_host_model.sv
// Purpose: host serial controller driving shift clock, select and word
// Assumes: clk_i at 25 MHz; eight ticks make one 320 ns shift clock
// Notes: shift clock stands low between cycles
`timescale 1ns/100ps
module asc_host_model (
    input wire clk_i,
    input wire sdo_i,
    output reg io_clk_o,
    output reg cs_n_o,
    output reg sdi_o
);
    initial begin
        io_clk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // one I/O cycle; output sampled just before each fall, when settled
    task run(input [7:0] w, input [4:0] nb, output [15:0] got);
        integer k;
        begin
            got = 16'h0000;
            cs_n_o <= 1'b0;
            for (k = 0; k < nb; k = k + 1) begin
                sdi_o <= (k < 8) ? w[7 - k] : 1'b0;
                repeat (4) @(posedge clk_i);
                io_clk_o <= 1'b1;
                repeat (4) @(posedge clk_i);
                got[k] = sdo_i;
                io_clk_o <= 1'b0;
            end
            repeat (4) @(posedge clk_i);
        end
    endtask
    // raise select between cycles; the shift clock stays low meanwhile
    task release_sel;
        begin
            cs_n_o <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
    endtask
endmodule // asc_host_model

// File: testbench/asc_top_bench.sv
// Purpose: self-checking bench for the control word decoder
// Assumes: host model on the pins, bench feeds results and the bus
// Notes: result tables are indexed by conversion number
`timescale 1ns/100ps
module asc_top_bench;
    reg clk_i = 1'b0;
    reg sys_rst_i = 1'b1;
    reg [3:0] avs_address_i = 4'h0;
    reg avs_read_i = 1'b0;
    reg avs_write_i = 1'b0;
    reg [31:0] avs_writedata_i = 32'h00000000;
    reg res_valid_i = 1'b0;
    reg [11:0] res_data_i = 12'h000;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, io_clk_i, cs_n_i, sdi_i, sdo_o, sdo_oe_n_o;
    wire eoc_o, conv_start_o, res_ready_o;
    wire [3:0] conv_sel_o;
    // words 0..7 (byte 0 first), one result and select per conversion
    localparam [63:0] WORDS = 64'h0CE0B8A23E2F150C;
    localparam [83:0] RESULTS = 84'h1236E9C335A78F03C1A5C;
    localparam [27:0] SELS = 28'h0BA3210;
    localparam [7:0] CHECKED = 8'h6E; // cycle 4 may be corrupt
    integer num_errors = 0;
    integer n_tests = 0;
    integer n_starts = 0;
    integer cyc = 0;
    integer i, t;
    reg [31:0] rd;
    reg [15:0] got;
    reg [7:0] w, pw;

    asc_top u_dut (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF),
        .avs_readdata_o, .avs_waitrequest_o, .io_clk_i, .cs_n_i, .sdi_i,
        .sdo_o, .sdo_oe_n_o, .eoc_o, .conv_start_o, .conv_sel_o,
        .res_valid_i, .res_ready_o, .res_data_i);
    asc_host_model u_host (.clk_i, .sdo_i(sdo_o), .io_clk_o(io_clk_i),
        .cs_n_o(cs_n_i), .sdi_o(sdi_i));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task check(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask

    task complete_run;
        begin
            $display("errors %0d checks %0d", num_errors, n_tests);
            if (num_errors == 0 && n_tests > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask

    // one Avalon access; request held until waitrequest is seen low
    task bus(input wr, input [3:0] a, input [31:0] d, output [31:0] q);
        begin
            @(posedge clk_i);
            avs_address_i <= a;
            avs_read_i <= !wr;
            avs_write_i <= wr;
            avs_writedata_i <= d;
            @(posedge clk_i);
            while (avs_waitrequest_o !== 1'b0)
                @(posedge clk_i);
            q = avs_readdata_o;
            avs_read_i <= 1'b0;
            avs_write_i <= 1'b0;
        end
    endtask

    function [4:0] len_of(input [7:0] c);
        len_of = (c[3:2] == 2'b01) ? 5'h08 : (c[3:2] == 2'b11) ? 5'h10 : 5'h0C;
    endfunction

    // bits as they should leave the serial output, bit k at index k
    function [15:0] exp_bits(input [11:0] r, input [4:0] len, input lsb,
                             input fmt);
        reg [15:0] img;
        integer k;
        begin
            img = {r[11] ^ fmt, r[10:0], 4'h0};
            exp_bits = 16'h0000;
            for (k = 0; k < len; k = k + 1)
                exp_bits[k] = lsb ? img[16 - len + k] : img[15 - k];
        end
    endfunction

    // converter stand-in: one result offered per started conversion
    always @(posedge clk_i) begin
        if (conv_start_o === 1'b1) begin
            check(conv_sel_o, SELS[4*n_starts +: 4]);
            res_data_i <= RESULTS[12*n_starts +: 12];
            res_valid_i <= 1'b1;
            n_starts <= n_starts + 1;
        end else if (res_ready_o === 1'b1) begin
            res_valid_i <= 1'b0;
        end
    end

    // hang guard: the whole run needs about 1150 cycles
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            complete_run;
        end
    end

    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        bus(1'b0, 4'h4, 32'h0, rd);
        check(rd, 32'h1); // enable set out of reset
        bus(1'b0, 4'hC, 32'h0, rd);
        check(rd, 32'h0); // unmapped place reads zero
        pw = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            w = WORDS[8*i +: 8];
            repeat (8) @(posedge clk_i);
            t = 0;
            while (eoc_o !== 1'b1 && t < 400) begin
                @(posedge clk_i);
                t = t + 1;
            end
            check(t < 400, 32'h1); // conversion done in time
            u_host.run(w, len_of(w), got);
            check(sdo_oe_n_o, 32'h0); // driven while selected
            if (CHECKED[i])
                check(got, exp_bits(RESULTS[12*(i-1) +: 12], len_of(w),
                    pw[1], pw[0]));
            if (i == 6) begin
                bus(1'b0, 4'h0, 32'h0, rd);
                check(rd[15:0], 16'h63E0);
            end
            pw = w;
        end
        repeat (20) @(posedge clk_i);
        check(n_starts, 7);
        bus(1'b0, 4'h8, 32'h0, rd);
        check(rd, 32'h00000123); // last result, unsigned
        bus(1'b1, 4'h4, 32'h0, rd);
        u_host.run(8'h5C, 5'h0C, got);
        repeat (20) @(posedge clk_i);
        check(n_starts, 7); // shift clock ignored while disabled
        bus(1'b0, 4'h0, 32'h0, rd);
        check(rd[7:0], 8'h0C);
        bus(1'b1, 4'h4, 32'h1, rd);
        u_host.release_sel;
        check(sdo_oe_n_o, 32'h1); // released while deselected
        complete_run;
    end
endmodule // asc_top_bench
